// ### logic/rfrx_defines.svh
// offsets, field positions, reset values and timing counts of the rx front end control
`ifndef RFRX_DEFINES_SVH
`define RFRX_DEFINES_SVH

// register offsets
`define RFRX_CHIP_STATE_CONTROL    8'h00
`define RFRX_RX_FILTER_SETTING     8'h09
`define RFRX_RX_GAIN_MIXER_SETTING 8'h0A
`define RFRX_REGULATOR_OUTPUT_CTRL 8'h0B
`define RFRX_GAIN_INTERNAL_STATUS  8'h0E
`define RFRX_SIGNAL_STRENGTH       8'h0F
`define RFRX_NOISE_GAIN_STATUS     8'h10
`define RFRX_MEASUREMENT_SELECT    8'h11
`define RFRX_MODULATOR_CONTROL     8'h15
`define RFRX_ADC_RESULT            8'h19

// direct command codes
`define RFRX_CMD_TRIGGER_ADC       8'h87

// chip_state_control fields
`define RFRX_AGC_ON_BIT            0
`define RFRX_AGL_ON_BIT            1
// rx_filter_setting fields
`define RFRX_BAND_LSB              1
`define RFRX_HP_HALF_BIT           3
`define RFRX_AC_FAST_BIT           4
// rx_gain_mixer_setting fields
`define RFRX_ATTEN_BIT             0
`define RFRX_LOWSUP_BIT            1
`define RFRX_SINGLE_BIT            2
`define RFRX_HYST_LSB              3
`define RFRX_AMP_LSB               5
// regulator_output_control fields
`define RFRX_AUX_EN_LSB            0
`define RFRX_PA_EN_LSB             2
`define RFRX_PA_DIFF_BIT           4
`define RFRX_AUX_MOD_BIT           5
`define RFRX_MAIN_MOD_BIT          6
// modulator_control fields
`define RFRX_DEPTH_LSB             0
`define RFRX_FULL_DEPTH_BIT        6
`define RFRX_PHASE_REV_BIT         7
// measurement select codes routing the mixer dc levels
`define RFRX_MSEL_MIXER_A          3'h1
`define RFRX_MSEL_MIXER_B          3'h2

// reset value and gain reduction limit
`define RFRX_RESET_BYTE            8'h00
`define RFRX_GAIN_MAX              3'h7

// timing
`define RFRX_CLK_MHZ               250
`define RFRX_ADC_VALID_NS          20000
`define RFRX_AGC_STEP_CYC          4'h8
`define RFRX_SETTLE_STEP_CYC       6'h20
`define RFRX_SETTLE_STEPS          2'h3

`endif

// ### logic/rfrx_pkg.sv
// types shared by the rx front end control
`default_nettype none
package rfrx_pkg;

  // noise-level gain sequencer
  typedef enum logic [1:0] {
    RFRX_AGL_IDLE,
    RFRX_AGL_RUN,
    RFRX_AGL_HOLD
  } rfrx_agl_t;

endpackage
`default_nettype wire

// ### logic/rfrx_ctrl.sv
// rx front end and modulator routing control with status capture
`default_nettype none
`include "rfrx_defines.svh"

module rfrx_ctrl #(
  parameter int unsigned ADC_WAIT_CYC = (`RFRX_ADC_VALID_NS * `RFRX_CLK_MHZ) / 1000
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // register port from host interface decoder
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // direct command strobe
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_code,
  // transceiver sequence events, same clock
  input  wire logic       tx_active,
  input  wire logic       rx_wait_done,
  input  wire logic       rx_end,
  input  wire logic       preamble_start,
  input  wire logic       preamble_end,
  // analog comparator and meter inputs, asynchronous
  input  wire logic       i_overrange,
  input  wire logic       q_overrange,
  input  wire logic       i_above_noise,
  input  wire logic       q_above_noise,
  input  wire logic       q_is_better,
  input  wire logic [3:0] i_level,
  input  wire logic [3:0] q_level,
  input  wire logic       sub_i,
  input  wire logic       sub_q,
  input  wire logic [7:0] adc_data,
  // modulator and amplifier controls
  output logic            mod_full_depth,
  output logic            mod_phase_rev,
  output logic      [5:0] mod_depth,
  output logic      [1:0] aux_out_en,
  output logic            aux_mod_en,
  output logic      [1:0] pa_en,
  output logic            pa_diff,
  output logic            main_mod_en,
  // mixer and filter controls
  output logic            mixer_atten,
  output logic            mixer_low_supply,
  output logic            mixer_single,
  output logic      [1:0] filter_band_sel,
  output logic            filter_hp_half,
  output logic            filter_ac_fast,
  output logic            dc_hold,
  output logic      [1:0] hp_settle,
  // gain controls
  output logic      [1:0] hyst_red,
  output logic      [2:0] i_gain_red,
  output logic      [2:0] q_gain_red,
  // measurement and receive data
  output logic            adc_mixer_sel,
  output logic            adc_start,
  output logic            rx_sub_data
);
  import rfrx_pkg::*;
  localparam logic [12:0] ADC_WAIT = 13'(ADC_WAIT_CYC);
  // whole module state
  typedef struct packed {
    logic [7:0] chip;       // chip_state_control
    logic [7:0] filt;       // rx_filter_setting
    logic [7:0] gmix;       // rx_gain_mixer_setting
    logic [7:0] outc;       // regulator_output_control
    logic [7:0] msel;       // measurement_select
    logic [7:0] modc;       // modulator_control
    logic [7:0] adc_res;    // adc_result
    logic [7:0] rdata;      // read data
    logic [9:0] s1_a;       // sync stage one, single bits
    logic [9:0] s2_a;       // sync stage two, single bits
    logic [15:0] s1_b;      // sync stage one, levels and adc
    logic [15:0] s2_b;      // sync stage two, levels and adc
    logic       tx_d;       // tx_active delayed
    logic [2:0] agc_red;    // agc reduction
    logic       agc_run;    // agc adjusting
    logic       agc_done;   // agc settled this telegram
    logic [3:0] agc_cnt;    // agc step spacing
    rfrx_agl_t  agl_st;     // noise gain sequencer
    logic [2:0] agl_i;      // noise gain i
    logic [2:0] agl_q;      // noise gain q
    logic       in_sel;     // 1 = q channel chosen
    logic       sel_valid;  // choice valid
    logic       rssi_win;   // peak tracking window
    logic [3:0] pk_i;       // i peak
    logic [3:0] pk_q;       // q peak
    logic [1:0] settle;     // high-pass settle step
    logic [5:0] settle_cnt; // settle step spacing
    logic       conv;       // conversion running
    logic [12:0] conv_cnt;  // conversion timer
    logic       start;      // adc start pulse
    logic       sub;        // selected subcarrier
  } rfrx_state_t;
  rfrx_state_t st_ff;
  rfrx_state_t nxt_st;
  // synchronised views, read only from stage two
  logic       ovr_i, ovr_q, nz_i, nz_q, qbet, sb_i, sb_q;
  logic [3:0] lv_i, lv_q;
  logic [7:0] adc_s;
  assign {ovr_i, ovr_q, nz_i, nz_q, qbet, sb_i, sb_q} = st_ff.s2_a[6:0];
  assign lv_i  = st_ff.s2_b[3:0];
  assign lv_q  = st_ff.s2_b[7:4];
  assign adc_s = st_ff.s2_b[15:8];
  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    // two-flop synchronisers for the analog side
    nxt_st.s1_a = {3'h0, i_overrange, q_overrange, i_above_noise, q_above_noise,
                   q_is_better, sub_i, sub_q};
    nxt_st.s2_a = st_ff.s1_a;
    nxt_st.s1_b = {adc_data, q_level, i_level};
    nxt_st.s2_b = st_ff.s1_b;
    nxt_st.tx_d = tx_active;
    nxt_st.start = 1'b0;

    // register writes; status registers ignore writes
    if (reg_wr) begin
      if (reg_addr == `RFRX_CHIP_STATE_CONTROL) begin
        nxt_st.chip = reg_wdata;
      end else if (reg_addr == `RFRX_RX_FILTER_SETTING) begin
        nxt_st.filt = reg_wdata;
      end else if (reg_addr == `RFRX_RX_GAIN_MIXER_SETTING) begin
        nxt_st.gmix = reg_wdata;
      end else if (reg_addr == `RFRX_REGULATOR_OUTPUT_CTRL) begin
        nxt_st.outc = reg_wdata;
      end else if (reg_addr == `RFRX_MEASUREMENT_SELECT) begin
        nxt_st.msel = reg_wdata;
      end else if (reg_addr == `RFRX_MODULATOR_CONTROL) begin
        nxt_st.modc = reg_wdata;
      end
    end

    // registered read data, unmapped reads return zero
    if (reg_rd) begin
      if (reg_addr == `RFRX_CHIP_STATE_CONTROL) begin
        nxt_st.rdata = st_ff.chip;
      end else if (reg_addr == `RFRX_RX_FILTER_SETTING) begin
        nxt_st.rdata = st_ff.filt;
      end else if (reg_addr == `RFRX_RX_GAIN_MIXER_SETTING) begin
        nxt_st.rdata = st_ff.gmix;
      end else if (reg_addr == `RFRX_REGULATOR_OUTPUT_CTRL) begin
        nxt_st.rdata = st_ff.outc;
      end else if (reg_addr == `RFRX_GAIN_INTERNAL_STATUS) begin
        nxt_st.rdata = {3'h0, st_ff.agc_done, st_ff.agc_red, st_ff.in_sel && st_ff.sel_valid};
      end else if (reg_addr == `RFRX_SIGNAL_STRENGTH) begin
        nxt_st.rdata = {st_ff.pk_q, st_ff.pk_i};
      end else if (reg_addr == `RFRX_NOISE_GAIN_STATUS) begin
        nxt_st.rdata = {1'b0, st_ff.agl_q, 1'b0, st_ff.agl_i};
      end else if (reg_addr == `RFRX_MEASUREMENT_SELECT) begin
        nxt_st.rdata = st_ff.msel;
      end else if (reg_addr == `RFRX_MODULATOR_CONTROL) begin
        nxt_st.rdata = st_ff.modc;
      end else if (reg_addr == `RFRX_ADC_RESULT) begin
        nxt_st.rdata = st_ff.adc_res;
      end else begin
        nxt_st.rdata = `RFRX_RESET_BYTE;
      end
    end

    if (tx_active) begin
      nxt_st.settle     = `RFRX_SETTLE_STEPS;
      nxt_st.settle_cnt = `RFRX_SETTLE_STEP_CYC;
    end else if (st_ff.settle != 2'h0) begin
      if (st_ff.settle_cnt == 6'h00) begin
        nxt_st.settle     = st_ff.settle - 2'h1;
        nxt_st.settle_cnt = `RFRX_SETTLE_STEP_CYC;
      end else begin
        nxt_st.settle_cnt = st_ff.settle_cnt - 6'h01;
      end
    end

    if (preamble_start && st_ff.chip[`RFRX_AGC_ON_BIT]) begin
      nxt_st.agc_red  = 3'h0;
      nxt_st.agc_run  = 1'b1;
      nxt_st.agc_done = 1'b0;
      nxt_st.agc_cnt  = 4'h0;
    end else if (st_ff.agc_run) begin
      if (preamble_end || !(ovr_i || ovr_q) || st_ff.agc_red == `RFRX_GAIN_MAX) begin
        // stop once neither channel is over range or the reduction reaches maximum and the step count has run out, or as soon as the preamble ends
        if (st_ff.agc_cnt == 4'h0 || preamble_end) begin
          nxt_st.agc_run  = 1'b0;
          nxt_st.agc_done = 1'b1;
        end else begin
          nxt_st.agc_cnt = st_ff.agc_cnt - 4'h1;
        end
      end else if (st_ff.agc_cnt == 4'h0) begin
        // step spacing lets the chain settle before re-judging
        nxt_st.agc_red = st_ff.agc_red + 3'h1;
        nxt_st.agc_cnt = `RFRX_AGC_STEP_CYC;
      end else begin
        nxt_st.agc_cnt = st_ff.agc_cnt - 4'h1;
      end
    end

    case (st_ff.agl_st)
      RFRX_AGL_IDLE: begin
        if (st_ff.chip[`RFRX_AGL_ON_BIT]) begin
          nxt_st.agl_st = RFRX_AGL_RUN;
          nxt_st.agl_i  = 3'h0;
          nxt_st.agl_q  = 3'h0;
        end
      end
      RFRX_AGL_RUN: begin
        if (!st_ff.chip[`RFRX_AGL_ON_BIT]) begin
          nxt_st.agl_st = RFRX_AGL_IDLE;
          nxt_st.agl_i  = 3'h0;
          nxt_st.agl_q  = 3'h0;
        end else begin
          if (nz_i && st_ff.agl_i != `RFRX_GAIN_MAX) begin
            nxt_st.agl_i = st_ff.agl_i + 3'h1;
          end
          if (nz_q && st_ff.agl_q != `RFRX_GAIN_MAX) begin
            nxt_st.agl_q = st_ff.agl_q + 3'h1;
          end
          if ((!nz_i || st_ff.agl_i == `RFRX_GAIN_MAX) &&
              (!nz_q || st_ff.agl_q == `RFRX_GAIN_MAX)) begin
            nxt_st.agl_st = RFRX_AGL_HOLD;
          end
        end
      end
      RFRX_AGL_HOLD: begin
        // held until software clears the bit
        if (!st_ff.chip[`RFRX_AGL_ON_BIT]) begin
          nxt_st.agl_st = RFRX_AGL_IDLE;
          nxt_st.agl_i  = 3'h0;
          nxt_st.agl_q  = 3'h0;
        end
      end
      default: begin
        nxt_st.agl_st = RFRX_AGL_IDLE;
      end
    endcase

    // latch i/q choice, set beats tx start
    if (preamble_end) begin
      nxt_st.in_sel    = qbet;
      nxt_st.sel_valid = 1'b1;
    end else if (tx_active && !st_ff.tx_d) begin
      nxt_st.sel_valid = 1'b0;
    end

    if (tx_active && !st_ff.tx_d) begin
      nxt_st.pk_i     = 4'h0;
      nxt_st.pk_q     = 4'h0;
      nxt_st.rssi_win = 1'b0;
    end else begin
      // peak hold over the rx window
      if (rx_wait_done) begin
        nxt_st.rssi_win = 1'b1;
      end else if (rx_end) begin
        nxt_st.rssi_win = 1'b0;
      end
      if (st_ff.rssi_win && lv_i > st_ff.pk_i) begin
        nxt_st.pk_i = lv_i;
      end
      if (st_ff.rssi_win && lv_q > st_ff.pk_q) begin
        nxt_st.pk_q = lv_q;
      end
    end

    if (cmd_valid && cmd_code == `RFRX_CMD_TRIGGER_ADC) begin
      nxt_st.start    = 1'b1;
      nxt_st.conv     = 1'b1;
      nxt_st.conv_cnt = ADC_WAIT;
    end else if (st_ff.conv) begin
      if (st_ff.conv_cnt == 13'h0001) begin
        nxt_st.adc_res = adc_s;
        nxt_st.conv    = 1'b0;
      end
      nxt_st.conv_cnt = st_ff.conv_cnt - 13'h0001;
    end

    // chosen channel to the digital receiver
    nxt_st.sub = st_ff.in_sel ? sb_q : sb_i;
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // full depth ask, depth sets delimiter
  assign mod_full_depth = st_ff.modc[`RFRX_FULL_DEPTH_BIT];
  assign mod_phase_rev  = st_ff.modc[`RFRX_PHASE_REV_BIT];
  assign mod_depth      = st_ff.modc[`RFRX_DEPTH_LSB +: 6];
  // low power output enable and drive
  assign aux_out_en     = st_ff.outc[`RFRX_AUX_EN_LSB +: 2];
  assign pa_en          = st_ff.outc[`RFRX_PA_EN_LSB +: 2];
  assign pa_diff        = st_ff.outc[`RFRX_PA_DIFF_BIT];
  assign aux_mod_en     = st_ff.outc[`RFRX_AUX_MOD_BIT] && (aux_out_en != 2'h0);
  assign main_mod_en    = st_ff.outc[`RFRX_MAIN_MOD_BIT] && (pa_en != 2'h0);
  assign mixer_atten      = st_ff.gmix[`RFRX_ATTEN_BIT];
  assign mixer_low_supply = st_ff.gmix[`RFRX_LOWSUP_BIT];
  assign mixer_single   = st_ff.gmix[`RFRX_SINGLE_BIT];
  // band code straight to the filter
  assign filter_band_sel = st_ff.filt[`RFRX_BAND_LSB +: 2];
  assign filter_hp_half = st_ff.filt[`RFRX_HP_HALF_BIT];
  assign filter_ac_fast = st_ff.filt[`RFRX_AC_FAST_BIT];
  assign dc_hold        = st_ff.tx_d;
  assign hp_settle      = st_ff.settle;
  assign hyst_red       = st_ff.gmix[`RFRX_HYST_LSB +: 2];
  // agl overrides, then agc, then manual gain
  assign i_gain_red = (st_ff.agl_st != RFRX_AGL_IDLE) ? st_ff.agl_i :
                      st_ff.chip[`RFRX_AGC_ON_BIT] ? st_ff.agc_red :
                      st_ff.gmix[`RFRX_AMP_LSB +: 3];
  assign q_gain_red = (st_ff.agl_st != RFRX_AGL_IDLE) ? st_ff.agl_q :
                      st_ff.chip[`RFRX_AGC_ON_BIT] ? st_ff.agc_red :
                      st_ff.gmix[`RFRX_AMP_LSB +: 3];
  // mixer dc to adc on either code
  assign adc_mixer_sel = (st_ff.msel[2:0] == `RFRX_MSEL_MIXER_A) ||
                         (st_ff.msel[2:0] == `RFRX_MSEL_MIXER_B);
  assign adc_start     = st_ff.start;
  assign rx_sub_data   = st_ff.sub;
  assign reg_rdata     = st_ff.rdata;

endmodule
`default_nettype wire

// ### verification/rfrx_host_model.sv
// host side model driving the register port and direct commands
`default_nettype none
module rfrx_host_model (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  // direct command strobe
  output logic            cmd_valid,
  output logic      [7:0] cmd_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    {reg_wr, reg_rd, cmd_valid} = 3'h0;
    {reg_addr, reg_wdata, cmd_code} = 24'h0;
  end
  // single byte write; released lines show inverted values so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // single byte read, data taken once the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  task automatic trig(input logic [7:0] c);
    @(negedge core_clk);
    cmd_code = c;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_code = ~c;
  endtask
endmodule
`default_nettype wire

// ### verification/rfrx_ctrl_asserts.sv
// port level assertions for the rx front end control
`default_nettype none
module rfrx_ctrl_asserts #(
  parameter int unsigned ADC_WAIT_CYC = 5000
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // register and command port
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic       tx_active,
  // watched outputs
  input wire logic       mod_full_depth,
  input wire logic       mod_phase_rev,
  input wire logic [5:0] mod_depth,
  input wire logic [1:0] aux_out_en,
  input wire logic       aux_mod_en,
  input wire logic [1:0] pa_en,
  input wire logic       pa_diff,
  input wire logic       main_mod_en,
  input wire logic       mixer_atten,
  input wire logic       mixer_low_supply,
  input wire logic       mixer_single,
  input wire logic [1:0] filter_band_sel,
  input wire logic       filter_hp_half,
  input wire logic       filter_ac_fast,
  input wire logic       dc_hold,
  input wire logic [1:0] hp_settle,
  input wire logic [1:0] hyst_red,
  input wire logic       adc_mixer_sel,
  input wire logic       adc_start
);
  // three settle steps of 33 cycles plus margin
  localparam int SETTLE_MAX = 110;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_adc_start_next: assert property (cmd_valid && cmd_code == 8'h87 |=> adc_start)
    else $error("no conversion start after trigger");
  a_adc_start_cause: assert property (adc_start |-> $past(cmd_valid) && $past(cmd_code) == 8'h87)
    else $error("conversion start without trigger");
  a_aux_mod_gate: assert property (reg_wr && reg_addr == 8'h0B |=>
      aux_mod_en == ($past(reg_wdata[5]) && $past(reg_wdata[1:0]) != 2'h0))
    else $error("aux modulation routing wrong");
  a_main_mod_gate: assert property (reg_wr && reg_addr == 8'h0B |=>
      main_mod_en == ($past(reg_wdata[6]) && $past(reg_wdata[3:2]) != 2'h0))
    else $error("main modulation routing wrong");
  a_dc_hold_follow: assert property ($rose(tx_active) |=> dc_hold ##1 dc_hold)
    else $error("dc points not held during transmit");
  a_settle_full: assert property (tx_active ##1 tx_active |-> hp_settle == 2'h3)
    else $error("settle not at full during transmit");
  a_settle_bound: assert property ($fell(tx_active) |-> ##[1:SETTLE_MAX] hp_settle == 2'h0)
    else $error("settle did not finish in time");
  a_mixer_write: assert property (reg_wr && reg_addr == 8'h0A |=>
      {mixer_single, mixer_low_supply, mixer_atten} == $past(reg_wdata[2:0])
      && hyst_red == $past(reg_wdata[4:3]))
    else $error("mixer controls differ from write");
  a_filter_write: assert property (reg_wr && reg_addr == 8'h09 |=>
      {filter_ac_fast, filter_hp_half, filter_band_sel} == $past(reg_wdata[4:1]))
    else $error("filter controls differ from write");
  a_mod_write: assert property (reg_wr && reg_addr == 8'h15 |=>
      {mod_phase_rev, mod_full_depth, mod_depth} == $past(reg_wdata))
    else $error("modulator controls differ from write");
  a_out_ctrl_write: assert property (reg_wr && reg_addr == 8'h0B |=>
      {pa_diff, pa_en, aux_out_en} == $past(reg_wdata[4:0]))
    else $error("output enables differ from write");
  a_msel_route: assert property (reg_wr && reg_addr == 8'h11 |=>
      adc_mixer_sel == ($past(reg_wdata[2:0]) inside {3'h1, 3'h2}))
    else $error("measurement routing wrong");
endmodule

bind rfrx_ctrl rfrx_ctrl_asserts #(.ADC_WAIT_CYC(ADC_WAIT_CYC)) u_asserts (
  .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_active(tx_active),
  .mod_full_depth(mod_full_depth), .mod_phase_rev(mod_phase_rev), .mod_depth(mod_depth),
  .aux_out_en(aux_out_en), .aux_mod_en(aux_mod_en), .pa_en(pa_en), .pa_diff(pa_diff),
  .main_mod_en(main_mod_en), .mixer_atten(mixer_atten), .mixer_low_supply(mixer_low_supply),
  .mixer_single(mixer_single), .filter_band_sel(filter_band_sel),
  .filter_hp_half(filter_hp_half), .filter_ac_fast(filter_ac_fast), .dc_hold(dc_hold),
  .hp_settle(hp_settle), .hyst_red(hyst_red), .adc_mixer_sel(adc_mixer_sel),
  .adc_start(adc_start));
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the rx front end control
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned ADC_WAIT = 20; // short conversion wait keeps the run brief
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       reg_wr, reg_rd, cmd_valid, tx_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cmd_code, adc_data;
  logic [3:0] ev, i_level, q_level;
  logic       i_ovr, q_ovr, i_nz, q_nz, q_better, sub_i, sub_q;
  logic       full_d, ph_rev, aux_me, pa_dif, main_me, m_att, m_low, m_sgl, hp_half, ac_fast;
  logic       dc_hold, adc_sel, adc_start, rx_sub;
  logic [5:0] mod_depth;
  logic [1:0] aux_en, pa_en, band, hp_settle, hyst;
  logic [2:0] i_gr, q_gr;
  int         miscompares = 0;
  int         checks_done = 0;
  logic [7:0] rw_a [6] = '{8'h00, 8'h09, 8'h0A, 8'h0B, 8'h11, 8'h15};
  logic [7:0] rw_d [6] = '{8'h00, 8'h1E, 8'hFF, 8'h7F, 8'h02, 8'h7F};
  logic [7:0] ro_a [5] = '{8'h0E, 8'h0F, 8'h10, 8'h19, 8'h05};

  always #2 core_clk = ~core_clk;

  rfrx_host_model host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code));

  rfrx_ctrl #(.ADC_WAIT_CYC(ADC_WAIT)) dut (.core_clk(core_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_active(tx_active),
    .rx_wait_done(ev[0]), .rx_end(ev[1]), .preamble_start(ev[2]), .preamble_end(ev[3]),
    .i_overrange(i_ovr), .q_overrange(q_ovr), .i_above_noise(i_nz), .q_above_noise(q_nz),
    .q_is_better(q_better), .i_level(i_level), .q_level(q_level), .sub_i(sub_i),
    .sub_q(sub_q), .adc_data(adc_data), .mod_full_depth(full_d), .mod_phase_rev(ph_rev),
    .mod_depth(mod_depth), .aux_out_en(aux_en), .aux_mod_en(aux_me), .pa_en(pa_en),
    .pa_diff(pa_dif), .main_mod_en(main_me), .mixer_atten(m_att), .mixer_low_supply(m_low),
    .mixer_single(m_sgl), .filter_band_sel(band), .filter_hp_half(hp_half),
    .filter_ac_fast(ac_fast), .dc_hold(dc_hold), .hp_settle(hp_settle), .hyst_red(hyst),
    .i_gain_red(i_gr), .q_gain_red(q_gr), .adc_mixer_sel(adc_sel), .adc_start(adc_start),
    .rx_sub_data(rx_sub));

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // compare a pin group against its expected value
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask
  // read a register and compare
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    host.rd(a, got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t reg %h got %h exp %h", $time, a, got, exp);
    end
  endtask
  // one cycle event pulse, then idle
  task automatic pulse(input int k);
    @(negedge core_clk);
    ev[k] = 1'b1;
    @(negedge core_clk);
    ev = 4'h0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  initial begin
    {ev, i_level, q_level, adc_data} = 20'h0;
    {tx_active, i_ovr, q_ovr, i_nz, q_nz, q_better, sub_i, sub_q} = 8'h0;
    cyc(10);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) chk_reg(rw_a[i], 8'h00);
    for (int i = 0; i < 5; i++) chk_reg(ro_a[i], 8'h00);
    chk_pin({7'h0, m_sgl}, 8'h00);
    host.wr(8'h19, 8'hFF);
    chk_reg(8'h19, 8'h00);
    for (int i = 0; i < 6; i++) host.wr(rw_a[i], rw_d[i]);
    for (int i = 0; i < 6; i++) chk_reg(rw_a[i], rw_d[i]);
    chk_pin({3'h0, band, hp_half, ac_fast, adc_sel}, 8'h1F);
    chk_pin({m_att, m_low, m_sgl, hyst, i_gr}, 8'hFF);
    chk_pin({1'b0, aux_en, pa_en, pa_dif, aux_me, main_me}, 8'h7F);
    chk_pin({ph_rev, full_d, mod_depth}, 8'h7F);
    $display("test registers done");
    for (int b = 0; b < 4; b++) begin
      host.wr(8'h09, 8'(b << 1));
      chk_pin({6'h0, band}, 8'(b));
    end
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h11, 8'(c));
      chk_pin({7'h0, adc_sel}, {7'h0, c == 1 || c == 2});
    end
    host.wr(8'h0B, 8'h1F);
    chk_pin({aux_en, pa_en, aux_me, main_me}, 8'h3C);
    host.wr(8'h0B, 8'h60);
    chk_pin({aux_en, pa_en, aux_me, main_me}, 8'h00);
    host.wr(8'h15, 8'h81);
    chk_pin({ph_rev, full_d, mod_depth}, 8'h81);
    $display("test fields done");
    adc_data = 8'hA5;
    host.trig(8'h87);
    chk_pin({7'h0, adc_start}, 8'h01);
    cyc(1);
    chk_pin({7'h0, adc_start}, 8'h00);
    chk_reg(8'h19, 8'h00);
    cyc(ADC_WAIT);
    chk_reg(8'h19, 8'hA5);
    adc_data = 8'h3C;
    cyc(5);
    chk_reg(8'h19, 8'hA5);
    host.trig(8'h88);
    chk_pin({7'h0, adc_start}, 8'h00);
    $display("test conversion done");
    {q_better, sub_q} = 2'h3;
    cyc(4);
    pulse(3);
    cyc(4);
    chk_reg(8'h0E, 8'h01);
    chk_pin({7'h0, rx_sub}, 8'h01);
    {sub_q, sub_i} = 2'h1;
    cyc(4);
    chk_pin({7'h0, rx_sub}, 8'h00);
    host.wr(8'h0A, 8'h40);
    host.wr(8'h00, 8'h01);
    i_ovr = 1'b1;
    pulse(2);
    cyc(90);
    chk_pin({2'h0, i_gr, q_gr}, 8'h3F);
    chk_reg(8'h0E, 8'h1F);
    pulse(2);
    chk_pin({5'h0, i_gr}, 8'h00);
    i_ovr = 1'b0;
    $display("test gain control done");
    i_nz = 1'b1;
    // noise gain set while no tag answers
    host.wr(8'h00, 8'h02);
    cyc(20);
    i_nz = 1'b0;
    cyc(5);
    chk_pin({2'h0, i_gr, q_gr}, 8'h38);
    chk_reg(8'h10, 8'h07);
    host.wr(8'h00, 8'h00);
    cyc(1);
    chk_pin({2'h0, i_gr, q_gr}, 8'h12);
    chk_reg(8'h10, 8'h00);
    $display("test noise gain done");
    tx_active = 1'b1;
    cyc(3);
    chk_pin({5'h0, dc_hold, hp_settle}, 8'h07);
    tx_active = 1'b0;
    cyc(5);
    chk_pin({6'h0, hp_settle}, 8'h03);
    for (int n = 0; hp_settle !== 2'h0; n++) begin
      if (n == 150) begin
        miscompares++;
        $display("[ERR] t=%0t settle got %h exp %h", $time, hp_settle, 2'h0);
        final_report();
      end
      cyc(1);
    end
    pulse(0);
    {i_level, q_level} = 8'h59;
    cyc(6);
    {i_level, q_level} = 8'h32;
    cyc(6);
    pulse(1);
    {i_level, q_level} = 8'hFF;
    cyc(6);
    chk_reg(8'h0F, 8'h95);
    tx_active = 1'b1;
    cyc(3);
    chk_reg(8'h0F, 8'h00);
    chk_reg(8'h0E, 8'h12);
    tx_active = 1'b0;
    $display("test signal strength done");
    final_report();
  end
endmodule
`default_nettype wire
